// ### spsp_dev_end.sv
`timescale 1ns/10ps
`include "spsp_cfg.svh"
module spsp_dev_end (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Link
    spsp_if.dev              link,
    // Analog front-end results
    input  wire logic [1:0]  op_mode,
    input  wire logic        cc_attached,
    input  wire logic        cc1_rd,
    input  wire logic        cc2_higher,
    input  wire logic [1:0]  sink_level,
    input  wire logic        local_overcurrent,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Results
    output logic [1:0]       advertised_current,
    output logic             port_power,
    output logic             irq
);
    // ****************************************************
    // Synchronisers and strap capture
    // ****************************************************
    logic [1:0]             poc_sync_reg, pen_sync_reg, ret_sync_reg;
    logic [1:0]             cap_sync_reg [2];
    logic                   cap_done_reg;
    spsp_pkg::spsp_mode_t   mode;
    spsp_pkg::spsp_pwr_t    pwr_reg;
    logic [15:0]            retry_cnt_reg;
    logic                   ctrl_en_reg, ctrl_oc_reg;
    logic [2:0]             irq_sts_reg, irq_msk_reg, irq_ev;
    logic                   att_d_reg, pwr_d_reg;
    logic                   oc_active, wr_acc;
    // Pins from the hub side pass two flops first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poc_sync_reg    <= 2'h3;
            pen_sync_reg    <= 2'h0;
            ret_sync_reg    <= 2'h0;
        end else begin
            poc_sync_reg    <= {poc_sync_reg[0], link.partner_overcurrent_n};
            pen_sync_reg    <= {pen_sync_reg[0], link.port_switch_enable_in};
            ret_sync_reg    <= {ret_sync_reg[0], link.auto_retry_sel};
        end
    end
    // Strap flops run through reset so the strap is settled at release;
    // a reset shorter than two clock edges would capture an unknown value
    always_ff @(posedge pclk) begin
        cap_sync_reg[0] <= {link.charge_current_sel_hi, link.charge_current_sel_lo};
        cap_sync_reg[1] <= cap_sync_reg[0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_done_reg       <= 1'b0;
            advertised_current <= `SPSP_CUR_USB2;
        end else if (!cap_done_reg) begin
            cap_done_reg       <= 1'b1;
            advertised_current <= cap_sync_reg[1];
        end
    end
    // Mode decode from core configuration
    always_comb begin
        unique case (op_mode)
            2'h1:    mode = spsp_pkg::SPSP_MODE_SRC;
            2'h2:    mode = spsp_pkg::SPSP_MODE_SNK;
            default: mode = spsp_pkg::SPSP_MODE_OFF;
        endcase
    end
    // ****************************************************
    // Port power and overcurrent recovery
    // ****************************************************
    // partner low is fault source
    assign oc_active = ~poc_sync_reg[1] | local_overcurrent;
    // Power only follows the hub enable while gated on by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg       <= spsp_pkg::SPSP_PWR_OFF;
            retry_cnt_reg <= 16'h0000;
            port_power    <= 1'b0;
        end else if (mode != spsp_pkg::SPSP_MODE_SRC) begin
            pwr_reg       <= spsp_pkg::SPSP_PWR_OFF;
            retry_cnt_reg <= 16'h0000;
            port_power    <= 1'b0;
        end else begin
            port_power <= (pwr_reg == spsp_pkg::SPSP_PWR_ON);
            unique case (pwr_reg)
                spsp_pkg::SPSP_PWR_OFF: begin
                    if (pen_sync_reg[1] && ctrl_en_reg && !oc_active) begin
                        pwr_reg <= spsp_pkg::SPSP_PWR_ON;
                    end
                end
                spsp_pkg::SPSP_PWR_ON: begin
                    if (oc_active) begin
                        pwr_reg <= spsp_pkg::SPSP_PWR_FAULT;
                    end else if (!pen_sync_reg[1] || !ctrl_en_reg) begin
                        pwr_reg <= spsp_pkg::SPSP_PWR_OFF;
                    end
                end
                spsp_pkg::SPSP_PWR_FAULT: begin
                    if (ret_sync_reg[1] && !oc_active) begin
                        pwr_reg       <= spsp_pkg::SPSP_PWR_RETRY;
                        retry_cnt_reg <= `SPSP_RETRY_CYC;
                    end
                end
                spsp_pkg::SPSP_PWR_RETRY: begin
                    if (oc_active) begin
                        pwr_reg <= spsp_pkg::SPSP_PWR_FAULT;
                    end else if (retry_cnt_reg == 16'h0000) begin
                        pwr_reg <= spsp_pkg::SPSP_PWR_OFF;
                    end else begin
                        retry_cnt_reg <= retry_cnt_reg - 16'h0001;
                    end
                end
            endcase
        end
    end
    // ****************************************************
    // Status pins
    // ****************************************************
    // Pins driven from flops; oe_n low means driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.attach                    <= 1'b0;
            link.attach_oe_n               <= 1'b1;
            link.orient                    <= 1'b0;
            link.orient_oe_n               <= 1'b1;
            link.overcurrent_report_n_out  <= 1'b0;
            link.overcurrent_report_n_oe_n <= 1'b1;
        end else begin
            link.attach_oe_n <= (mode == spsp_pkg::SPSP_MODE_OFF);
            link.orient_oe_n <= (mode == spsp_pkg::SPSP_MODE_OFF);
            link.attach <= (mode != spsp_pkg::SPSP_MODE_OFF) & cc_attached;
            if (mode == spsp_pkg::SPSP_MODE_SRC) begin
                link.orient <= ~cc1_rd;
            end else if (mode == spsp_pkg::SPSP_MODE_SNK) begin
                link.orient <= cc2_higher;
            end else begin
                link.orient <= 1'b0;
            end
            link.overcurrent_report_n_out  <= 1'b0;
            link.overcurrent_report_n_oe_n <= !((mode == spsp_pkg::SPSP_MODE_SRC)
                                                && (local_overcurrent || ctrl_oc_reg));
        end
    end
    // Sink level outputs, active low, at most one driven low at a time, all three enabled together while in sink mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.sink_legacy_level_n <= 1'b1;
            link.sink_mid_level_n    <= 1'b1;
            link.sink_high_level_n   <= 1'b1;
            link.sink_levels_oe_n    <= 1'b1;
        end else begin
            link.sink_levels_oe_n <= (mode != spsp_pkg::SPSP_MODE_SNK);
            link.sink_legacy_level_n <= !((mode == spsp_pkg::SPSP_MODE_SNK) && cc_attached
                                          && (sink_level == `SPSP_LVL_LEGACY));
            link.sink_mid_level_n    <= !((mode == spsp_pkg::SPSP_MODE_SNK) && cc_attached
                                          && (sink_level == `SPSP_LVL_MID));
            link.sink_high_level_n   <= !((mode == spsp_pkg::SPSP_MODE_SNK) && cc_attached
                                          && (sink_level == `SPSP_LVL_HIGH));
        end
    end
    // ****************************************************
    // Registers and interrupts
    // ****************************************************
    assign wr_acc = psel && penable && pwrite;
    assign irq_ev[`SPSP_IRQ_OC_BIT]  = oc_active;
    assign irq_ev[`SPSP_IRQ_ATT_BIT] = link.attach != att_d_reg;
    assign irq_ev[`SPSP_IRQ_PWR_BIT] = port_power != pwr_d_reg;
    // Edge history for event detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            att_d_reg <= 1'b0;
            pwr_d_reg <= 1'b0;
        end else begin
            att_d_reg <= link.attach;
            pwr_d_reg <= port_power;
        end
    end
    // Control, mask and sticky status; a set beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_reg <= 1'b1;
            ctrl_oc_reg <= 1'b0;
            irq_msk_reg <= `SPSP_IRQ_MSK_RST;
            irq_sts_reg <= 3'h0;
        end else begin
            if (wr_acc && paddr == `SPSP_OFF_CTRL) begin
                ctrl_en_reg <= pwdata[`SPSP_CTRL_EN_BIT];
                ctrl_oc_reg <= pwdata[`SPSP_CTRL_OC_BIT];
            end
            if (wr_acc && paddr == `SPSP_OFF_IRQ_MSK) begin
                irq_msk_reg <= pwdata[2:0];
            end
            if (wr_acc && paddr == `SPSP_OFF_IRQ_STS) begin
                irq_sts_reg <= (irq_sts_reg & ~pwdata[2:0]) | irq_ev;
            end else begin
                irq_sts_reg <= irq_sts_reg | irq_ev;
            end
        end
    end
    // APB read data, zero-wait answer, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == `SPSP_OFF_CTRL || paddr == `SPSP_OFF_STAT
                       || paddr == `SPSP_OFF_IRQ_STS || paddr == `SPSP_OFF_IRQ_MSK);
            unique case (paddr)
                `SPSP_OFF_CTRL:    prdata <= {30'h0, ctrl_oc_reg, ctrl_en_reg};
                `SPSP_OFF_STAT:    prdata <= {25'h0, port_power, advertised_current,
                                              mode, link.orient, link.attach};
                `SPSP_OFF_IRQ_STS: prdata <= {29'h0, irq_sts_reg};
                `SPSP_OFF_IRQ_MSK: prdata <= {29'h0, irq_msk_reg};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end
    // Level interrupt plus open-drain pin
    // active low open-drain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq             <= 1'b0;
            link.irq_n_out  <= 1'b0;
            link.irq_n_oe_n <= 1'b1;
        end else begin
            irq             <= |(irq_sts_reg & irq_msk_reg);
            link.irq_n_out  <= 1'b0;
            link.irq_n_oe_n <= ~|(irq_sts_reg & irq_msk_reg);
        end
    end
endmodule

// ### spsp_cfg.svh
`ifndef SPSP_CFG_SVH
`define SPSP_CFG_SVH
// Charge current select codes
`define SPSP_CUR_USB2     2'h0
`define SPSP_CUR_USB3     2'h1
`define SPSP_CUR_1A5      2'h2
`define SPSP_CUR_3A0      2'h3
// Sink detected level codes
`define SPSP_LVL_NONE     2'h0
`define SPSP_LVL_LEGACY   2'h1
`define SPSP_LVL_MID      2'h2
`define SPSP_LVL_HIGH     2'h3
// Controller register offsets
`define SPSP_OFF_CTRL     12'h000
`define SPSP_OFF_STAT     12'h004
`define SPSP_OFF_IRQ_STS  12'h008
`define SPSP_OFF_IRQ_MSK  12'h00C
// Control fields
`define SPSP_CTRL_EN_BIT  0
`define SPSP_CTRL_OC_BIT  1
// Interrupt status fields
`define SPSP_IRQ_OC_BIT   0
`define SPSP_IRQ_ATT_BIT  1
`define SPSP_IRQ_PWR_BIT  2
`define SPSP_IRQ_MSK_RST  3'h0
// Retry delay after overcurrent, in cycles
`define SPSP_RETRY_CYC    16'h00FF
`endif

// ### spsp_pkg.sv
package spsp_pkg;
    typedef enum logic [1:0] {SPSP_MODE_OFF, SPSP_MODE_SRC, SPSP_MODE_SNK} spsp_mode_t;
    typedef enum logic [1:0] {SPSP_PWR_OFF, SPSP_PWR_ON, SPSP_PWR_FAULT, SPSP_PWR_RETRY} spsp_pwr_t;
endpackage

// ### spsp_if.sv
`timescale 1ns/10ps
// Pins between port controller and hub. The open-drain report pin carries in/out/oe_n; the interrupt pin has out/oe_n only.
interface spsp_if;
    logic       attach;
    logic       attach_oe_n;
    logic       orient;
    logic       orient_oe_n;
    logic       overcurrent_report_n_out;
    logic       overcurrent_report_n_oe_n;
    logic       overcurrent_report_n_in;
    logic       partner_overcurrent_n;
    logic       port_switch_enable_in;
    logic       charge_current_sel_lo;
    logic       charge_current_sel_hi;
    logic       auto_retry_sel;
    logic       sink_legacy_level_n;
    logic       sink_mid_level_n;
    logic       sink_high_level_n;
    logic       sink_levels_oe_n;
    logic       irq_n_out;
    logic       irq_n_oe_n;
    // Open-drain wired level, idle high through weak pull-up
    assign overcurrent_report_n_in = overcurrent_report_n_oe_n ? 1'b1 : overcurrent_report_n_out;
    modport dev (
        output attach, attach_oe_n, orient, orient_oe_n,
        output overcurrent_report_n_out, overcurrent_report_n_oe_n,
        input  partner_overcurrent_n, port_switch_enable_in,
        input  charge_current_sel_lo, charge_current_sel_hi, auto_retry_sel,
        output sink_legacy_level_n, sink_mid_level_n, sink_high_level_n, sink_levels_oe_n,
        output irq_n_out, irq_n_oe_n
    );
    modport hub (
        input  attach, attach_oe_n, orient, orient_oe_n,
        input  overcurrent_report_n_in,
        output partner_overcurrent_n, port_switch_enable_in,
        output charge_current_sel_lo, charge_current_sel_hi, auto_retry_sel
    );
endinterface

// ### spsp_hub_end.sv
`timescale 1ns/10ps
`include "spsp_cfg.svh"
// Hub end: drives straps, power enable and its own overcurrent report,
// and watches attach, orientation and the device overcurrent report.
module spsp_hub_end #(
    parameter logic [1:0] CUR_STRAP = `SPSP_CUR_USB2
) (
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Link
    spsp_if.hub        link,
    // User side
    input  wire logic  hub_power_on,
    input  wire logic  hub_overcurrent,
    input  wire logic  hub_auto_retry,
    output logic       seen_attach,
    output logic       seen_orient,
    output logic       seen_dev_overcurrent
);
    logic [1:0] att_sync_reg;
    logic [1:0] ori_sync_reg;
    logic [1:0] oc_sync_reg;
    logic       pwr_reg;
    logic       hoc_n_reg;
    logic       retry_reg;

    // Straps are constants from reset onward, never changed after release
    // straps held stable
    assign link.charge_current_sel_lo = CUR_STRAP[0];
    assign link.charge_current_sel_hi = CUR_STRAP[1];

    // Registered drives toward the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_reg   <= 1'b0;
            hoc_n_reg <= 1'b1;
            retry_reg <= 1'b0;
        end else begin
            pwr_reg   <= hub_power_on;
            hoc_n_reg <= ~hub_overcurrent;
            retry_reg <= hub_auto_retry;
        end
    end
    assign link.port_switch_enable_in = pwr_reg;
    assign link.partner_overcurrent_n = hoc_n_reg;
    assign link.auto_retry_sel        = retry_reg;

    // Synchronise device pins; released pins read as idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            att_sync_reg <= 2'h0;
            ori_sync_reg <= 2'h0;
            oc_sync_reg  <= 2'h3;
        end else begin
            att_sync_reg <= {att_sync_reg[0], link.attach & ~link.attach_oe_n};
            ori_sync_reg <= {ori_sync_reg[0], link.orient & ~link.orient_oe_n};
            oc_sync_reg  <= {oc_sync_reg[0], link.overcurrent_report_n_in};
        end
    end

    // User outputs from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_attach          <= 1'b0;
            seen_orient          <= 1'b0;
            seen_dev_overcurrent <= 1'b0;
        end else begin
            seen_attach          <= att_sync_reg[1];
            seen_orient          <= ori_sync_reg[1];
            seen_dev_overcurrent <= ~oc_sync_reg[1];
        end
    end
endmodule

// ### spsp_sva.sv
`timescale 1ns/10ps
// ************************************************************
// Link pin checker
// ************************************************************
module spsp_sva (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Device status pins
    input wire logic attach_oe_n,
    input wire logic orient_oe_n,
    input wire logic overcurrent_report_n_out,
    input wire logic overcurrent_report_n_oe_n,
    input wire logic overcurrent_report_n_in,
    input wire logic sink_legacy_level_n,
    input wire logic sink_mid_level_n,
    input wire logic sink_high_level_n,
    input wire logic sink_levels_oe_n,
    input wire logic irq_n_out,
    input wire logic irq_n_oe_n,
    // Hub straps
    input wire logic charge_current_sel_lo,
    input wire logic charge_current_sel_hi
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // End of a low pull, the line must float back up
    sequence s_pull_end;
        !overcurrent_report_n_oe_n ##1 overcurrent_report_n_oe_n;
    endsequence

    AST_REPORT_OD: assert property (!overcurrent_report_n_oe_n |-> !overcurrent_report_n_out)
        else $error("report pin driven high");
    AST_REPORT_IDLE: assert property (s_pull_end |-> overcurrent_report_n_in[*2])
        else $error("report line not idle high after release");
    AST_IRQ_OD: assert property (!irq_n_oe_n |-> !irq_n_out)
        else $error("interrupt pin driven high");
    AST_SINK_ONE: assert property (!sink_levels_oe_n |->
        $onehot0(~{sink_high_level_n, sink_mid_level_n, sink_legacy_level_n}))
        else $error("more than one sink level asserted");
    AST_STATUS_PAIR: assert property (attach_oe_n == orient_oe_n)
        else $error("attach and orientation enables differ");
    AST_SINK_NO_REPORT: assert property (!sink_levels_oe_n |-> overcurrent_report_n_oe_n)
        else $error("report pulled in sink mode");
    AST_STRAP_LO: assert property ($stable(charge_current_sel_lo))
        else $error("low strap changed after reset");
    AST_STRAP_HI: assert property ($stable(charge_current_sel_hi))
        else $error("high strap changed after reset");
endmodule

// ### tb_standalone_port_status_pins.sv
`timescale 1ns/10ps
`include "spsp_cfg.svh"
// ************************************************************
// Bench for both ends joined by the link
// ************************************************************
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %0t: mismatch got %h exp %h", $time, g, e); end end
module tb_standalone_port_status_pins;
    logic        pclk = 1'b0;
    logic        presetn;
    logic [1:0]  op_mode, sink_level, adv_cur;
    logic [1:0]  adv_x [1:3];
    logic        cc_attached, cc1_rd, cc2_higher, local_overcurrent;
    logic        psel, penable, pwrite, pready, pslverr, err, port_power, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  exp3;
    logic        hub_power_on, hub_overcurrent, hub_auto_retry;
    logic        seen_attach, seen_orient, seen_dev_overcurrent;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n;
    // ************************************************************
    // Clock, timeout and instances
    // ************************************************************
    always #20 pclk = ~pclk;
    // Whole run needs about 750 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            finish_test();
        end
    end
    spsp_if link_if ();
    spsp_hub_end #(.CUR_STRAP(2'h2)) i_spsp_hub_end (.pclk, .presetn, .link(link_if), .hub_power_on,
        .hub_overcurrent, .hub_auto_retry, .seen_attach, .seen_orient, .seen_dev_overcurrent);
    spsp_dev_end i_spsp_dev_end (.pclk, .presetn, .link(link_if), .op_mode, .cc_attached, .cc1_rd,
        .cc2_higher, .sink_level, .local_overcurrent, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .advertised_current(adv_cur), .port_power, .irq);
    // Extra pairs only show strap codes 1 to 3
    for (genvar g = 1; g < 4; g++) begin : g_strap
        spsp_if x_if ();
        spsp_hub_end #(.CUR_STRAP(2'(g))) i_spsp_hub_end (.pclk, .presetn, .link(x_if), .hub_power_on,
            .hub_overcurrent, .hub_auto_retry, .seen_attach(), .seen_orient(), .seen_dev_overcurrent());
        spsp_dev_end i_spsp_dev_end (.pclk, .presetn, .link(x_if), .op_mode, .cc_attached, .cc1_rd,
            .cc2_higher, .sink_level, .local_overcurrent, .psel, .penable, .pwrite, .paddr, .pwdata,
            .prdata(), .pready(), .pslverr(),
            .advertised_current(adv_x[g]), .port_power(), .irq());
    end
    spsp_sva i_spsp_sva (.pclk, .presetn, .attach_oe_n(link_if.attach_oe_n),
        .orient_oe_n(link_if.orient_oe_n), .overcurrent_report_n_out(link_if.overcurrent_report_n_out),
        .overcurrent_report_n_oe_n(link_if.overcurrent_report_n_oe_n),
        .overcurrent_report_n_in(link_if.overcurrent_report_n_in),
        .sink_legacy_level_n(link_if.sink_legacy_level_n), .sink_mid_level_n(link_if.sink_mid_level_n),
        .sink_high_level_n(link_if.sink_high_level_n), .sink_levels_oe_n(link_if.sink_levels_oe_n),
        .irq_n_out(link_if.irq_n_out), .irq_n_oe_n(link_if.irq_n_oe_n),
        .charge_current_sel_lo(link_if.charge_current_sel_lo),
        .charge_current_sel_hi(link_if.charge_current_sel_hi));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        `CHK(adv_cur, 2'h2)
        for (int i = 1; i < 4; i++) `CHK(adv_x[i], 2'(i))
        `CHK(link_if.attach_oe_n, 1'b1)
        apb(1'b0, `SPSP_OFF_CTRL, 32'h0);
        `CHK(rd, 32'h00000001)
        apb(1'b0, `SPSP_OFF_IRQ_MSK, 32'h0);
        `CHK(rd, 32'h00000000)
        apb(1'b1, 12'h010, 32'hFFFFFFFF);
        `CHK(err, 1'b1)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        $display("t_regs done");
    endtask
    task automatic t_source();
        op_mode <= 2'h1;
        cc_attached <= 1'b1;
        cc1_rd <= 1'b1;
        tick(6);
        `CHK(link_if.attach_oe_n, 1'b0)
        `CHK({link_if.attach, link_if.orient, seen_attach}, 3'h5)
        apb(1'b0, `SPSP_OFF_STAT, 32'h0);
        `CHK(rd, 32'h00000025)
        cc1_rd <= 1'b0;
        tick(6);
        `CHK({link_if.orient, seen_orient}, 2'h3)
        cc_attached <= 1'b0;
        tick(6);
        `CHK({link_if.attach, seen_attach}, 2'h0)
        $display("t_source done");
    endtask
    task automatic t_sink();
        op_mode <= 2'h2;
        cc_attached <= 1'b1;
        tick(6);
        `CHK({link_if.attach_oe_n, link_if.attach, link_if.orient}, 3'h2)
        cc2_higher <= 1'b1;
        tick(6);
        `CHK(link_if.orient, 1'b1)
        for (int l = 0; l < 4; l++) begin
            sink_level <= 2'(l);
            exp3 = 3'h7;
            if (l > 0) exp3[l-1] = 1'b0;
            tick(4);
            `CHK({link_if.sink_high_level_n, link_if.sink_mid_level_n, link_if.sink_legacy_level_n}, exp3)
        end
        sink_level <= 2'h0;
        $display("t_sink done");
    endtask
    task automatic t_off();
        op_mode <= 2'h3;
        local_overcurrent <= 1'b1;
        tick(6);
        `CHK({link_if.attach_oe_n, link_if.orient_oe_n, link_if.overcurrent_report_n_oe_n}, 3'h7)
        local_overcurrent <= 1'b0;
        $display("t_off done");
    endtask
    task automatic t_power();
        op_mode <= 2'h1;
        hub_power_on <= 1'b1;
        tick(8);
        `CHK(port_power, 1'b1)
        hub_power_on <= 1'b0;
        tick(8);
        `CHK(port_power, 1'b0)
        hub_power_on <= 1'b1;
        tick(8);
        local_overcurrent <= 1'b1;
        tick(4);
        local_overcurrent <= 1'b0;
        tick(300);
        `CHK(port_power, 1'b0)
        hub_auto_retry <= 1'b1;
        n = 0;
        while (port_power !== 1'b1 && n < 600) begin
            tick(1);
            n++;
        end
        `CHK({port_power, n > `SPSP_RETRY_CYC}, 2'h3)
        hub_power_on <= 1'b0;
        hub_auto_retry <= 1'b0;
        tick(8);
        $display("t_power done");
    endtask
    task automatic t_oc();
        local_overcurrent <= 1'b1;
        tick(6);
        `CHK({link_if.overcurrent_report_n_in, seen_dev_overcurrent}, 2'h1)
        local_overcurrent <= 1'b0;
        tick(6);
        `CHK({link_if.overcurrent_report_n_in, seen_dev_overcurrent}, 2'h2)
        hub_overcurrent <= 1'b1;
        tick(8);
        `CHK({link_if.partner_overcurrent_n, irq, link_if.irq_n_oe_n}, 3'h1)
        apb(1'b1, `SPSP_OFF_IRQ_MSK, 32'h00000001);
        tick(4);
        `CHK({irq, link_if.irq_n_oe_n, link_if.irq_n_out}, 3'h4)
        apb(1'b0, `SPSP_OFF_IRQ_STS, 32'h0);
        `CHK(rd[`SPSP_IRQ_OC_BIT], 1'b1)
        hub_overcurrent <= 1'b0;
        tick(6);
        apb(1'b1, `SPSP_OFF_IRQ_STS, 32'h00000001);
        tick(4);
        `CHK({irq, link_if.irq_n_oe_n}, 2'h1)
        apb(1'b1, `SPSP_OFF_CTRL, 32'h00000002);
        hub_power_on <= 1'b1;
        tick(8);
        `CHK({port_power, link_if.overcurrent_report_n_in, seen_dev_overcurrent}, 3'h1)
        apb(1'b1, `SPSP_OFF_CTRL, 32'h00000001);
        tick(8);
        `CHK({port_power, link_if.overcurrent_report_n_in}, 2'h3)
        hub_power_on <= 1'b0;
        tick(8);
        $display("t_oc done");
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, cc_attached, cc1_rd, cc2_higher, local_overcurrent} = 7'h00;
        {hub_power_on, hub_overcurrent, hub_auto_retry} = 3'h0;
        {op_mode, sink_level, paddr, pwdata} = 48'h0;
        tick(2);
        presetn <= 1'b1;
        tick(3);
        t_regs();
        t_source();
        t_sink();
        t_off();
        t_power();
        t_oc();
        finish_test();
    end
endmodule
